// ---- hdl/sdc_front.sv ----
// Purpose: Command, address and clock-gating front end of a 4-bank SDRAM.
// Assumes: All inputs except the asynchronous reset are synchronous to clk.
// Notes:   Produces decoded strobes and burst addresses for the array core.
`timescale 1ns/10ps
module sdc_front
  import sdc_pkg::*;
#(
  parameter int ROWS = 2048,
  parameter int COLS = 256
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst,
  // Command bus from the controller.
  input  wire sdc_cmd_type       cmd_in,
  input  wire logic              cke,
  input  wire logic [MASK_W-1:0] byte_mask,
  // Data from the array core and to it.
  input  wire logic [DATA_W-1:0] core_rdata,
  input  wire logic [DATA_W-1:0] data_io_in,
  output      logic [DATA_W-1:0] data_io_out,
  output      logic [MASK_W-1:0] data_io_oe_n,
  output      logic              core_we,
  output      logic [MASK_W-1:0] core_lane_we,
  output      logic [DATA_W-1:0] core_wdata,
  output      logic [BANK_W-1:0] core_bank,
  output      logic [ROW_W-1:0]  core_row,
  output      logic [COL_W-1:0]  core_col,
  // Status.
  output      logic [3:0]        bank_open,
  output      logic [MODE_W-1:0] mode_word,
  output      logic              in_pdown,
  output      logic              in_sref,
  output      logic              auto_pre_start
);

  ////////////////////////////////////////////////////////////////////////////
  // Command decode on the sampled bus.
  logic [3:0] cmd_code;
  logic       cke_prev;
  logic       live;
  sdc_pwr_type pwr, next_pwr;
  assign cmd_code = {cmd_in.cs_n, cmd_in.ras_n,
                     cmd_in.cas_n, cmd_in.we_n};
  // Low power stops decoding; a deselect collapses into no operation.
  assign live = cke_prev && !cmd_in.cs_n && (pwr == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Power state, bank state, mode word and burst tracking.
  logic [3:0]        next_bank_open;
  logic [ROW_W-1:0]  row_reg [4];
  logic [ROW_W-1:0]  next_row_reg [4];
  logic [MODE_W-1:0] next_mode_word;
  logic              bursting, next_bursting;
  logic              is_write, next_is_write;
  logic              ap_pend, next_ap_pend;
  logic [BANK_W-1:0] bank_q, next_bank_q;
  logic [COL_W-1:0]  start_col, next_start_col;
  logic [COL_W-1:0]  cnt, next_cnt;
  logic [COL_W:0]    left, next_left;
  logic              next_auto_pre;
  logic              next_cke_prev;
  logic [COL_W:0]    blen;

  // Burst length in words from the mode word; full page is one row.
  always_comb begin
    case (mode_word[BL_LSB +: 3])
      3'h0:    blen = 9'h001;
      3'h1:    blen = 9'h002;
      3'h2:    blen = 9'h004;
      3'h3:    blen = 9'h008;
      default: blen = 9'h100;
    endcase
  end

  always_comb begin
    next_pwr       = pwr;
    next_bank_open = bank_open;
    next_row_reg   = row_reg;
    next_mode_word = mode_word;
    next_bursting  = bursting;
    next_is_write  = is_write;
    next_ap_pend   = ap_pend;
    next_bank_q    = bank_q;
    next_start_col = start_col;
    next_cnt       = cnt;
    next_left      = left;
    next_auto_pre  = 1'b0;
    next_cke_prev  = cke;
    case (pwr)
      ST_RUN: begin
        if (!cke && cke_prev && bank_open == 4'h0 && !bursting) begin
          // Refresh code with enable falling enters self refresh.
          if (!cmd_in.cs_n && cmd_code == CMD_REF)
            next_pwr = ST_SREF;
          else
            next_pwr = ST_PDOWN;
        end
      end
      ST_PDOWN, ST_SREF: begin
        // Only clock enable is watched here.
        if (cke)
          next_pwr = ST_RUN;
      end
      default: next_pwr = ST_RUN;
    endcase
    // Burst steps on every unsuspended edge; a new command overrides it.
    if (cke_prev && bursting) begin
      next_cnt  = cnt + 8'h01;
      next_left = left - 9'h001;
      if (left == 9'h001 && mode_word[BL_LSB +: 3] != BL_FULL) begin
        next_bursting = 1'b0;
        if (ap_pend) begin
          next_auto_pre = 1'b1;
          next_bank_open[bank_q] = 1'b0;
          next_ap_pend = 1'b0;
        end
      end
    end
    if (live) begin
      case (cmd_code)
        CMD_ACT: begin
          next_bank_open[cmd_in.bank_select_bits] = 1'b1;
          next_row_reg[cmd_in.bank_select_bits] = cmd_in.addr;
        end
        CMD_PRE: begin
          if (cmd_in.addr[10])
            next_bank_open = 4'h0;
          else
            next_bank_open[cmd_in.bank_select_bits] = 1'b0;
        end
        CMD_RD, CMD_WR: begin
          // Column access to a closed bank is ignored.
          if (bank_open[cmd_in.bank_select_bits]) begin
            next_bursting  = 1'b1;
            next_is_write  = (cmd_code == CMD_WR);
            next_ap_pend   = cmd_in.addr[10];
            next_bank_q    = cmd_in.bank_select_bits;
            next_start_col = cmd_in.addr[COL_W-1:0];
            next_cnt       = 8'h00;
            next_left      = blen;
          end
        end
        CMD_MRS: begin
          if (bank_open == 4'h0)
            next_mode_word = cmd_in.addr;
        end
        CMD_STOP: begin
          next_bursting = 1'b0;
          next_ap_pend  = 1'b0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr            <= ST_RUN;
      bank_open      <= 4'h0;
      row_reg        <= '{default: '0};
      mode_word      <= MODE_RESET;
      bursting       <= 1'b0;
      is_write       <= 1'b0;
      ap_pend        <= 1'b0;
      bank_q         <= '0;
      start_col      <= '0;
      cnt            <= '0;
      left           <= '0;
      auto_pre_start <= 1'b0;
      cke_prev       <= 1'b1;
    end else begin
      pwr            <= next_pwr;
      bank_open      <= next_bank_open;
      row_reg        <= next_row_reg;
      mode_word      <= next_mode_word;
      bursting       <= next_bursting;
      is_write       <= next_is_write;
      ap_pend        <= next_ap_pend;
      bank_q         <= next_bank_q;
      start_col      <= next_start_col;
      cnt            <= next_cnt;
      left           <= next_left;
      auto_pre_start <= next_auto_pre;
      cke_prev       <= next_cke_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Column address: linear adds, interleaved XORs the low bits.
  logic [COL_W-1:0] col_now;
  logic [2:0]       wrap_mask;
  always_comb begin
    case (mode_word[BL_LSB +: 3])
      3'h1:    wrap_mask = 3'h1;
      3'h2:    wrap_mask = 3'h3;
      3'h3:    wrap_mask = 3'h7;
      default: wrap_mask = 3'h0;
    endcase
    if (mode_word[BL_LSB +: 3] == BL_FULL)
      col_now = start_col + cnt;
    else if (mode_word[BT_BIT])
      col_now = {start_col[COL_W-1:3],
                 start_col[2:0] ^ (cnt[2:0] & wrap_mask)};
    else
      col_now = {start_col[COL_W-1:3], (start_col[2:0] & ~wrap_mask) |
                 ((start_col[2:0] + cnt[2:0]) & wrap_mask)};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read pipeline: latency 2 or 3; mask delayed two cycles.
  logic [DATA_W-1:0] rd_pipe [3];
  logic [2:0]        rv_pipe, next_rv_pipe;
  logic [MASK_W-1:0] mask_pipe [MASK_LAT];
  logic [DATA_W-1:0] next_rd_pipe [3];
  logic [MASK_W-1:0] next_mask_pipe [MASK_LAT];
  logic              rd_hit;
  logic [DATA_W-1:0] next_dout;
  logic [MASK_W-1:0] next_oe_n, next_lane_we;
  logic [DATA_W-1:0] wdata_q;
  logic [COL_W-1:0]  next_col;

  always_comb begin
    rd_hit         = bursting && !is_write && cke_prev;
    next_rd_pipe   = rd_pipe;
    next_rv_pipe   = rv_pipe;
    next_mask_pipe = mask_pipe;
    next_dout      = data_io_out;
    next_oe_n      = data_io_oe_n;
    next_lane_we   = 4'h0;
    next_col       = core_col;
    if (cke_prev) begin
      // The column is held while suspended so no word is skipped.
      next_col = col_now;
      next_rd_pipe = '{core_rdata, rd_pipe[0], rd_pipe[1]};
      next_rv_pipe = {rv_pipe[1:0], rd_hit};
      next_mask_pipe = '{byte_mask, mask_pipe[0]};
      // Latency 3 reads one stage further down.
      if (mode_word[CL_LSB +: 3] == 3'h3) begin
        next_dout = rd_pipe[1];
        next_oe_n = rv_pipe[2] ? mask_pipe[MASK_LAT-1] : 4'hf;
      end else begin
        next_dout = rd_pipe[0];
        next_oe_n = rv_pipe[1] ? mask_pipe[MASK_LAT-1] : 4'hf;
      end
      // Write mask is sampled with the column; write data is the word of the previous edge, even a suspended one.
      if (bursting && is_write)
        next_lane_we = ~mask_pipe[0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_pipe      <= '{default: '0};
      rv_pipe      <= 3'h0;
      mask_pipe    <= '{default: '0};
      data_io_out  <= '0;
      data_io_oe_n <= 4'hf;
      core_lane_we <= 4'h0;
      core_we      <= 1'b0;
      core_wdata   <= '0;
      wdata_q      <= '0;
      core_bank    <= '0;
      core_row     <= '0;
      core_col     <= '0;
      in_pdown     <= 1'b0;
      in_sref      <= 1'b0;
    end else begin
      rd_pipe      <= next_rd_pipe;
      rv_pipe      <= next_rv_pipe;
      mask_pipe    <= next_mask_pipe;
      data_io_out  <= next_dout;
      data_io_oe_n <= next_oe_n;
      core_lane_we <= next_lane_we;
      core_we      <= |next_lane_we;
      wdata_q      <= data_io_in;
      core_wdata   <= wdata_q;
      core_bank    <= bank_q;
      core_row     <= row_reg[bank_q];
      core_col     <= next_col;
      in_pdown     <= (next_pwr == ST_PDOWN);
      in_sref      <= (next_pwr == ST_SREF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks. Full-page count covers COLS words; row store covers ROWS.
  property p_stop;
    @(posedge clk) disable iff (rst)
      (live && cmd_code == CMD_STOP) |=> !bursting;
  endproperty
  a_stop: assert property (p_stop) else $error("burst not stopped");

  property p_pall;
    @(posedge clk) disable iff (rst)
      (live && cmd_code == CMD_PRE && cmd_in.addr[10]) |=> bank_open == 4'h0;
  endproperty
  a_pall: assert property (p_pall) else $error("banks left open");

  property p_desel;
    @(posedge clk) disable iff (rst)
      (cmd_in.cs_n && !bursting) |=> $stable(bank_open) && $stable(mode_word);
  endproperty
  a_desel: assert property (p_desel) else $error("deselect acted");

  property p_freeze;
    @(posedge clk) disable iff (rst)
      (!cke_prev && pwr == ST_RUN) |=> $stable(cnt) && $stable(data_io_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("not frozen");

  property p_act;
    @(posedge clk) disable iff (rst)
      (live && cmd_code == CMD_ACT)
        |=> bank_open[$past(cmd_in.bank_select_bits)];
  endproperty
  a_act: assert property (p_act) else $error("bank not opened");

  property p_lp;
    @(posedge clk) disable iff (rst)
      (pwr != ST_RUN) |-> !live;
  endproperty
  a_lp: assert property (p_lp) else $error("decode in low power");

  property p_mrs;
    @(posedge clk) disable iff (rst)
      (live && cmd_code == CMD_MRS && bank_open == 4'h0)
        |=> mode_word == $past(cmd_in.addr);
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode not loaded");

  property p_ap;
    @(posedge clk) disable iff (rst)
      auto_pre_start |-> !bank_open[bank_q];
  endproperty
  a_ap: assert property (p_ap) else $error("auto precharge missed");

  property p_size;
    @(posedge clk) disable iff (rst) 1'b1 |-> (ROWS == 2048 && COLS == 256);
  endproperty
  a_size: assert property (p_size) else $error("bank geometry");

endmodule : sdc_front

// ---- hdl/sdc_pkg.sv ----
// Purpose: Shared constants and types for the SDRAM command front end.
// Assumes: One 20 MHz clock, asynchronous active-high reset.
// Notes:   Mode word layout is the conventional burst/latency layout.
package sdc_pkg;

  localparam int ROW_W  = 11;
  localparam int COL_W  = 8;
  localparam int BANK_W = 2;
  localparam int DATA_W = 32;
  localparam int MASK_W = 4;
  localparam int MODE_W = 11;

  // Mode word field positions and reset value.
  localparam int BL_LSB      = 0;
  localparam int BT_BIT      = 3;
  localparam int CL_LSB      = 4;
  localparam logic [10:0] MODE_RESET = 11'h020;
  localparam logic [2:0]  BL_FULL    = 3'h7;
  localparam int MASK_LAT = 2;

  // Command code is {cs_n, ras_n, cas_n, we_n}.
  localparam logic [3:0] CMD_ACT  = 4'h3;
  localparam logic [3:0] CMD_PRE  = 4'h2;
  localparam logic [3:0] CMD_RD   = 4'h5;
  localparam logic [3:0] CMD_WR   = 4'h4;
  localparam logic [3:0] CMD_MRS  = 4'h0;
  localparam logic [3:0] CMD_REF  = 4'h1;
  localparam logic [3:0] CMD_STOP = 4'h6;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] bank_select_bits;
    logic [ROW_W-1:0]  addr;
  } sdc_cmd_type;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_PDOWN = 2'b01,
    ST_SREF  = 2'b10
  } sdc_pwr_type;

endpackage : sdc_pkg

// ---- testbench/sdc_core_model.sv ----
// Purpose: Behavioural array core that sits behind the front end.
// Assumes: Reads are combinational from bank, row and column.
// Notes:   Unwritten words read as a pattern made from their address.
`timescale 1ns/10ps
module sdc_core_model
  import sdc_pkg::*;
(
  // Clock.
  input  wire logic              clk,
  // Array access from the front end.
  input  wire logic              core_we,
  input  wire logic [MASK_W-1:0] core_lane_we,
  input  wire logic [DATA_W-1:0] core_wdata,
  input  wire logic [BANK_W-1:0] core_bank,
  input  wire logic [ROW_W-1:0]  core_row,
  input  wire logic [COL_W-1:0]  core_col,
  // Read data back to the front end.
  output      logic [DATA_W-1:0] core_rdata
);
  logic [DATA_W-1:0] mem [logic [20:0]];
  logic [DATA_W-1:0] w;
  int                wr_cnt = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Address pattern, so a wrong bank, row or column shows in the data.
  function automatic logic [31:0] pat(input logic [1:0] b,
                                      input logic [10:0] r,
                                      input logic [7:0] c);
    return {c, r, b, 11'h2a5};
  endfunction : pat

  // Current content of one location.
  function automatic logic [31:0] peek(input logic [1:0] b,
                                       input logic [10:0] r,
                                       input logic [7:0] c);
    return mem.exists({b, r, c}) ? mem[{b, r, c}] : pat(b, r, c);
  endfunction : peek

  ////////////////////////////////////////////////////////////////////////////
  // Only enabled lanes are written; the count wakes the read process.
  always @(posedge clk) begin
    if (core_we === 1'b1) begin
      w = peek(core_bank, core_row, core_col);
      for (int i = 0; i < 4; i++) begin
        if (core_lane_we[i]) w[8*i+:8] = core_wdata[8*i+:8];
      end
      mem[{core_bank, core_row, core_col}] = w;
      wr_cnt++;
    end
  end

  // Read port follows the address with no delay.
  always @(core_bank, core_row, core_col, wr_cnt) begin
    core_rdata = peek(core_bank, core_row, core_col);
  end
endmodule : sdc_core_model

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for the SDRAM command front end.
// Assumes: The array core model answers on the core ports.
// Notes:   Commands are driven by non-blocking assignment on rising edges.
`timescale 1ns/10ps
module tb
  import sdc_pkg::*;
;
  logic              clk;
  logic              rst;
  sdc_cmd_type       cmd_in;
  logic              cke;
  logic [MASK_W-1:0] byte_mask, data_io_oe_n, core_lane_we;
  logic [DATA_W-1:0] data_io_in, data_io_out, core_rdata, core_wdata, e;
  logic              core_we, in_pdown, in_sref, auto_pre_start;
  logic [BANK_W-1:0] core_bank;
  logic [ROW_W-1:0]  core_row;
  logic [COL_W-1:0]  core_col;
  logic [3:0]        bank_open;
  logic [MODE_W-1:0] mode_word;
  int                num_errors = 0, n_tests = 0, ap_cnt = 0;
  logic [10:0] md [6] = '{11'h020, 11'h021, 11'h03a, 11'h02b, 11'h032, 11'h027};
  logic [7:0]  cs [6] = '{8'hff, 8'h01, 8'h05, 8'h05, 8'h0e, 8'hfe};

  sdc_front DUT (.clk, .rst, .cmd_in, .cke, .byte_mask, .core_rdata,
    .data_io_in, .data_io_out, .data_io_oe_n, .core_we, .core_lane_we,
    .core_wdata, .core_bank, .core_row, .core_col, .bank_open, .mode_word,
    .in_pdown, .in_sref, .auto_pre_start);
  sdc_core_model u_core (.clk, .core_we, .core_lane_we, .core_wdata,
    .core_bank, .core_row, .core_col, .core_rdata);

  ////////////////////////////////////////////////////////////////////////////
  // Free-running clock at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Count auto-precharge pulses so none slips by between checks.
  always @(posedge clk) begin
    if (auto_pre_start === 1'b1) ap_cnt++;
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                     input logic [10:0] a);
    @(posedge clk);
    cmd_in <= {c, b, a};
  endtask : cmd

  task automatic settle;
    cmd(4'h7, 2'h0, 11'h000);
    @(posedge clk);
    #1;
  endtask : settle

  // Read burst; s is the edge at which clock enable is sampled low.
  task automatic rd(input logic [1:0] b, input logic [10:0] r, ca,
                    input int cl, bl, ilv, s, input logic [3:0] m);
    logic [7:0]  c, w, col;
    logic [31:0] mk;
    int          n, j;
    c = ca[7:0];
    n = (bl == 7) ? 3 : (1 << bl);
    w = (bl == 7) ? 8'hff : 8'(n - 1);
    cmd(CMD_RD, b, ca);
    cmd(4'h7, 2'h0, 11'h000);
    byte_mask <= (cl == 2) ? m : 4'h0;
    for (int k = 1; k <= cl + n + (s > 0); k++) begin
      @(posedge clk);
      byte_mask <= (k + 2 == cl) ? m : 4'h0;
      cke       <= (k + 1 != s);
      #1;
      j = ((s > 0 && k > s) ? k - 1 : k) - cl - 1;
      if (j < 0) begin
        chk(data_io_oe_n, 4'hf, "lanes idle before data");
      end else begin
        col = ilv ? (c ^ 8'(j)) : ((c & ~w) | ((c + 8'(j)) & w));
        mk  = (j == 0) ? {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}} : 0;
        chk(data_io_oe_n, (j == 0) ? m : 4'h0, "lane enables");
        e = u_core.peek(b, r, col);
        chk(data_io_out & ~mk, e & ~mk, "read data");
      end
    end
    if (bl != 7) begin
      @(posedge clk);
      #1;
      chk(data_io_oe_n, 4'hf, "burst ended");
    end
  endtask : rd

  task automatic conclude;
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  // A hang counts as a mismatch; the tests need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    conclude;
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    cke = 1'b1;
    byte_mask = 4'h0;
    data_io_in = 32'h0;
    cmd_in = {4'hf, 2'h0, 11'h000};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(mode_word, 11'h020, "mode after reset");
    chk(data_io_oe_n, 4'hf, "lanes after reset");
    cmd(4'hb, 2'h1, 11'h000);
    settle;
    chk(bank_open, 4'h0, "deselected command acted");
    // Open every bank, try a mode set, close one bank and then all.
    for (int b = 0; b < 4; b++) cmd(CMD_ACT, 2'(b), 11'h100);
    cmd(CMD_MRS, 2'h0, 11'h033);
    cmd(CMD_PRE, 2'h2, 11'h000);
    settle;
    chk(bank_open, 4'hb, "single bank precharge");
    chk(mode_word, 11'h020, "mode set with open bank");
    cmd(CMD_PRE, 2'h0, 11'h400);
    settle;
    chk(bank_open, 4'h0, "precharge all");
    // Each burst mode, with a lane mask and a clock suspend on the way.
    for (int i = 0; i < 6; i++) begin
      cmd(CMD_PRE, 2'h0, 11'h400);
      cmd(CMD_MRS, 2'h0, md[i]);
      settle;
      chk(mode_word, md[i], "mode load");
      cmd(CMD_ACT, 2'(i), 11'h7ff ^ 11'(i * 37));
      rd(2'(i), 11'h7ff ^ 11'(i * 37), {3'h0, cs[i]},
         (md[i][6:4] == 3) ? 3 : 2, md[i][2:0], md[i][3],
         (i == 3) ? 4 : 0, (i == 2) ? 4'h2 : 4'h0);
    end
    cmd(CMD_STOP, 2'h0, 11'h000);
    settle;
    repeat (3) @(posedge clk);
    #1;
    chk(data_io_oe_n, 4'hf, "burst stop");
    chk(ap_cnt, 0, "stray auto precharge");
    // A read to a closed bank is refused.
    cmd(CMD_PRE, 2'h0, 11'h400);
    cmd(CMD_RD, 2'h0, 11'h000);
    settle;
    repeat (4) begin
      @(posedge clk);
      #1;
      chk(data_io_oe_n, 4'hf, "closed bank read");
    end
    // Auto-precharge closes the bank after the burst by itself.
    cmd(CMD_MRS, 2'h0, 11'h022);
    cmd(CMD_ACT, 2'h1, 11'h055);
    rd(2'h1, 11'h055, 11'h410, 2, 2, 0, 0, 4'h0);
    repeat (6) @(posedge clk);
    #1;
    chk(ap_cnt, 1, "auto precharge pulse");
    chk(bank_open, 4'h0, "auto precharge close");
    // Masked write burst, then read back.
    cmd(CMD_ACT, 2'h3, 11'h0aa);
    cmd(CMD_WR, 2'h3, 11'h008);
    data_io_in <= 32'ha5000000;
    for (int i = 1; i < 4; i++) begin
      cmd(4'h7, 2'h0, 11'h000);
      data_io_in <= 32'ha5000000 + i;
      byte_mask  <= (i == 1) ? 4'h5 : 4'h0;
    end
    settle;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      e = 32'ha5000000 + i;
      if (i == 1) e = (e & 32'hff00ff00) |
                      (u_core.pat(2'h3, 11'h0aa, 8'h09) & 32'h00ff00ff);
      chk(u_core.peek(2'h3, 11'h0aa, 8'(8 + i)), e, "stored word");
    end
    rd(2'h3, 11'h0aa, 11'h008, 2, 2, 0, 0, 4'h0);
    // Low clock enable with a bank open only suspends.
    @(posedge clk);
    cke <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(in_pdown, 1'b0, "power down with open bank");
    @(posedge clk);
    cke <= 1'b1;
    // Power down ignores commands until clock enable returns.
    cmd(CMD_PRE, 2'h0, 11'h400);
    settle;
    @(posedge clk);
    cke <= 1'b0;
    cmd(CMD_ACT, 2'h0, 11'h000);
    settle;
    chk(in_pdown, 1'b1, "power down entry");
    chk(bank_open, 4'h0, "command in power down");
    @(posedge clk);
    cke <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(in_pdown, 1'b0, "power down exit");
    // Refresh code with clock enable falling enters self refresh.
    cmd(CMD_REF, 2'h0, 11'h000);
    cke <= 1'b0;
    settle;
    chk(in_sref, 1'b1, "self refresh entry");
    @(posedge clk);
    cke <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(in_sref, 1'b0, "self refresh exit");
    conclude;
  end
endmodule : tb
